// >>> hssc_spin_clock.sv
// Horizon-pulse synchronized spin clock generator
`timescale 1ns/100ps
`default_nettype none
`include "hssc_defs.svh"

module hssc_spin_clock
	import hssc_pkg::*;
#(
	parameter logic [11:0]            WIN_OPEN    = `HSSC_WIN_OPEN,
	parameter logic [11:0]            FREE_CLOSE  = `HSSC_FREE_CLOSE,
	parameter logic [11:0]            SHORT_CLOSE = `HSSC_SHORT_CLOSE,
	// Crystal step and binary stage count; a larger step and fewer stages only for quick runs
	parameter logic [`HSSC_ACC_W-1:0] XTAL_STEP   = `HSSC_XTAL_STEP,
	parameter int                     DIV2_STAGES = `HSSC_DIV2_STAGES
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic load_done,
	input  wire logic quarter_orbit_torque_mode,
	input  wire logic cam_sel,
	input  wire logic sens_a_set,
	input  wire logic sens_a_clr,
	input  wire logic sens_b_set,
	input  wire logic sens_b_clr,
	output logic      tick_400,
	output logic      horizon_pulse,
	output logic      spin_clock,
	output logic      window_open,
	output logic      synced
);

	////////////////////////////////////////////////////////////////////////////
	// Crystal emulation and divide chain

	logic [`HSSC_ACC_W-1:0]       acc_ff;
	logic [`HSSC_ACC_W:0]         nxt_acc;
	logic                         xtal_edge;
	logic [DIV2_STAGES-1:0]       div2_ff;
	logic [1:0]                   div3_ff;
	logic                         div_wrap;

	assign nxt_acc   = {1'b0, acc_ff} + {1'b0, XTAL_STEP};
	assign xtal_edge = nxt_acc[`HSSC_ACC_W];
	assign div_wrap  = xtal_edge && (&div2_ff) && (div3_ff == `HSSC_DIV3_MAX);

	// Phase accumulator gives one crystal cycle per carry
	always_ff @(posedge clock) begin
		if (!rst_b)
			acc_ff <= '0;
		else
			acc_ff <= nxt_acc[`HSSC_ACC_W-1:0];
	end

	// Binary stages then divide-by-three down to 400 Hz
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			div2_ff <= '0;
			div3_ff <= '0;
		end else if (xtal_edge) begin
			div2_ff <= div2_ff + 1'b1;
			if (&div2_ff)
				div3_ff <= (div3_ff == `HSSC_DIV3_MAX) ? 2'h0 : div3_ff + 2'h1;
		end
	end

	// Tick strobe
	always_ff @(posedge clock) begin
		if (!rst_b)
			tick_400 <= 1'b0;
		else
			tick_400 <= div_wrap;
	end

	////////////////////////////////////////////////////////////////////////////
	// Earth blanking and horizon recognition

	logic blank_ff;
	logic pend_ff;
	logic sens_set;
	logic sens_clr;

	// Camera selection picks the normal sensor pair
	assign sens_set = cam_sel ? sens_b_set : sens_a_set;
	assign sens_clr = cam_sel ? sens_b_clr : sens_a_clr;

	// Blanking flip-flop: set at sky-earth, cleared by opposite sensor
	always_ff @(posedge clock) begin
		if (!rst_b)
			blank_ff <= 1'b0;
		else if (sens_set && !blank_ff)
			blank_ff <= 1'b1;
		else if (sens_clr)
			blank_ff <= 1'b0;
	end

	// Pending edge held until the next tick; set wins over clear
	always_ff @(posedge clock) begin
		if (!rst_b)
			pend_ff <= 1'b0;
		else if (sens_set && !blank_ff)
			pend_ff <= 1'b1;
		else if (tick_400)
			pend_ff <= 1'b0;
	end

	// Tick-aligned horizon strobe
	always_ff @(posedge clock) begin
		if (!rst_b)
			horizon_pulse <= 1'b0;
		else
			horizon_pulse <= div_wrap && (pend_ff || (sens_set && !blank_ff));
	end

	////////////////////////////////////////////////////////////////////////////
	// Synchronizing and error logic

	hssc_state_e          state_ff;
	logic [11:0]          cnt_ff;
	hssc_err_e            err_type_ff;
	logic [`HSSC_ERR_W-1:0] err_cnt_ff;
	logic                 missing_ff;
	logic                 hp;
	logic                 early;
	logic                 late;
	logic                 at_close;
	logic                 in_win;
	logic                 rephase;
	logic                 fill_in;

	assign hp        = horizon_pulse && !quarter_orbit_torque_mode;
	// Window counts from its opening count; a late state does not shut it
	assign in_win    = (cnt_ff >= WIN_OPEN);
	assign window_open = (state_ff == HSSC_RUN) && (cnt_ff >= WIN_OPEN);
	// Close point shortens while pulses are missing
	assign at_close  = cnt_ff == (missing_ff ? SHORT_CLOSE : FREE_CLOSE);
	assign early     = hp && (cnt_ff < WIN_OPEN);
	// Pulse after a clock made at window expiry counts as late
	assign fill_in   = err_type_ff == HSSC_ERR_LATE || missing_ff;
	assign late      = hp && fill_in && (cnt_ff < WIN_OPEN) && (err_type_ff == HSSC_ERR_LATE);
	assign rephase   = hp && (early || late) && (err_type_ff == (early && !late ? HSSC_ERR_EARLY : HSSC_ERR_LATE))
		&& (err_cnt_ff == `HSSC_ERR_REPHASE);

	// Acquisition state
	always_ff @(posedge clock) begin
		if (!rst_b)
			state_ff <= HSSC_IDLE;
		else begin
			case (state_ff)
				HSSC_IDLE:  if (load_done) state_ff <= HSSC_ARMED;
				HSSC_ARMED: if (horizon_pulse || (quarter_orbit_torque_mode && tick_400)) state_ff <= HSSC_RUN;
				HSSC_RUN:   if (!load_done) state_ff <= HSSC_IDLE;
				default:    state_ff <= HSSC_IDLE;
			endcase
		end
	end

	// Window counter; recycles without losing a tick
	always_ff @(posedge clock) begin
		if (!rst_b || state_ff != HSSC_RUN)
			cnt_ff <= '0;
		else if (tick_400) begin
			// A pulse after a missing run rephases wherever it falls
			if ((hp && in_win) || at_close || rephase || (hp && missing_ff))
				cnt_ff <= 12'h001;
			else
				cnt_ff <= cnt_ff + 12'h001;
		end
	end

	// Missing-pulse flag: set by a close with no pulse while no error type is held, cleared by any pulse outside quarter-orbit torque mode
	always_ff @(posedge clock) begin
		if (!rst_b || state_ff != HSSC_RUN)
			missing_ff <= 1'b0;
		else if (hp)
			missing_ff <= 1'b0;
		else if (tick_400 && at_close && err_type_ff == HSSC_ERR_NONE)
			missing_ff <= 1'b1;
	end

	// Error type and count
	always_ff @(posedge clock) begin
		if (!rst_b || state_ff != HSSC_RUN) begin
			err_type_ff <= HSSC_ERR_NONE;
			err_cnt_ff  <= '0;
		end else if (hp && in_win) begin
			err_type_ff <= HSSC_ERR_NONE;
			err_cnt_ff  <= '0;
		end else if (tick_400 && at_close && !hp && !missing_ff && err_type_ff == HSSC_ERR_NONE) begin
			err_type_ff <= HSSC_ERR_LATE;
			err_cnt_ff  <= '0;
		end else if (hp && (early || late)) begin
			if (err_type_ff == HSSC_ERR_NONE || err_type_ff != (late ? HSSC_ERR_LATE : HSSC_ERR_EARLY)) begin
				// First pulse of a new type is error one of four
				err_type_ff <= late ? HSSC_ERR_LATE : HSSC_ERR_EARLY;
				err_cnt_ff  <= `HSSC_ERR_FIRST;
			end else if (rephase)
				err_cnt_ff <= err_cnt_ff;
			else
				err_cnt_ff <= err_cnt_ff + 1'b1;
		end
	end

	// Output clock strobe
	always_ff @(posedge clock) begin
		if (!rst_b)
			spin_clock <= 1'b0;
		else if (state_ff == HSSC_ARMED)
			spin_clock <= horizon_pulse || (quarter_orbit_torque_mode && tick_400);
		else if (state_ff == HSSC_RUN && tick_400)
			spin_clock <= (hp && in_win) || at_close || (rephase && !late)
				|| (hp && missing_ff && !early);
		else
			spin_clock <= 1'b0;
	end

	assign synced = (state_ff == HSSC_RUN) && (err_type_ff == HSSC_ERR_NONE) && !missing_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_armed_hit;
		state_ff == HSSC_ARMED && horizon_pulse;
	endsequence

	property p_first_clock;
		@(posedge clock) disable iff (!rst_b) s_armed_hit |=> spin_clock;
	endproperty
	a_first_clock: assert property (p_first_clock) else $error("No first clock");

	property p_clock_single;
		@(posedge clock) disable iff (!rst_b) spin_clock |=> !spin_clock;
	endproperty
	a_clock_single: assert property (p_clock_single) else $error("Clock pulse too wide");

	property p_hp_single;
		@(posedge clock) disable iff (!rst_b) horizon_pulse |=> !horizon_pulse;
	endproperty
	a_hp_single: assert property (p_hp_single) else $error("Horizon pulse too wide");

	property p_hp_on_tick;
		@(posedge clock) disable iff (!rst_b) horizon_pulse |-> tick_400;
	endproperty
	a_hp_on_tick: assert property (p_hp_on_tick) else $error("Horizon pulse off tick");

	property p_idle_quiet;
		@(posedge clock) disable iff (!rst_b) state_ff == HSSC_IDLE |=> !spin_clock;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("Clock before load");

	property p_cnt_bound;
		@(posedge clock) disable iff (!rst_b) cnt_ff <= FREE_CLOSE;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("Counter passed close");

	property p_close_clock;
		@(posedge clock) disable iff (!rst_b)
			state_ff == HSSC_RUN && tick_400 && at_close |=> spin_clock;
	endproperty
	a_close_clock: assert property (p_close_clock) else $error("No clock at close");

	property p_win_clock;
		@(posedge clock) disable iff (!rst_b)
			state_ff == HSSC_RUN && hp && in_win |=> spin_clock && cnt_ff == 12'h001;
	endproperty
	a_win_clock: assert property (p_win_clock) else $error("In-window pulse lost");

	property p_tick_gap;
		@(posedge clock) disable iff (!rst_b) tick_400 |=> !tick_400;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("Tick too wide");

	// Rephase checks: early fourth error restarts counter with a clock,
	// a pulse after a missing run restarts the counter at its arrival
	sequence s_early_fourth;
		state_ff == HSSC_RUN && rephase && !late;
	endsequence

	property p_early_rephase;
		@(posedge clock) disable iff (!rst_b) s_early_fourth |=> spin_clock && cnt_ff == 12'h001;
	endproperty
	a_early_rephase: assert property (p_early_rephase) else $error("Early rephase lost");

	property p_miss_rephase;
		@(posedge clock) disable iff (!rst_b)
			state_ff == HSSC_RUN && hp && missing_ff |=> cnt_ff == 12'h001;
	endproperty
	a_miss_rephase: assert property (p_miss_rephase) else $error("Missing-run rephase lost");

endmodule

`default_nettype wire

// >>> hssc_defs.svh
// Constants for the horizon-synchronized spin clock
`ifndef HSSC_DEFS_SVH
`define HSSC_DEFS_SVH

// System clock rate and crystal reference
`define HSSC_SYS_HZ        100_000_000
`define HSSC_XTAL_HZ       2_457_600
`define HSSC_TICK_HZ       400
// Phase accumulator emulating the crystal oscillator from the system clock
`define HSSC_ACC_W         32
`define HSSC_XTAL_STEP     32'h064A_9CDC
// Crystal divide chain: 2457600 / 400 = 6144 = 2^11 * 3
`define HSSC_DIV2_STAGES   11
`define HSSC_DIV3_MAX      2'h2
// Window counter
`define HSSC_CNT_W         12
`define HSSC_WIN_OPEN      12'h0800
`define HSSC_FREE_CLOSE    12'h08C0
`define HSSC_SHORT_CLOSE   12'h08A2
// Recorded-camera close counts, for overriding the window parameters
`define HSSC_REC_FREE_CLOSE  12'h0A50
`define HSSC_REC_SHORT_CLOSE 12'h0A32
// Errors before rephase
`define HSSC_ERR_W         2
`define HSSC_ERR_FIRST     2'h1
`define HSSC_ERR_REPHASE   2'h3

`endif

// >>> hssc_pkg.sv
// Types for the horizon-synchronized spin clock
package hssc_pkg;
	typedef enum logic [1:0] {
		HSSC_IDLE,
		HSSC_ARMED,
		HSSC_RUN
	} hssc_state_e;

	typedef enum logic [1:0] {
		HSSC_ERR_NONE,
		HSSC_ERR_EARLY,
		HSSC_ERR_LATE
	} hssc_err_e;
endpackage

// >>> hssc_sensor_model.sv
// Horizon sensor pair model: sky-earth edge, then the opposite sensor
`timescale 1ns/100ps
`default_nettype none
module hssc_sensor_model (
	input  wire logic clock,
	input  wire logic fire_a,
	input  wire logic fire_b,
	output logic      sens_a_set,
	output logic      sens_a_clr,
	output logic      sens_b_set,
	output logic      sens_b_clr
);
	logic [5:0] ph_ff   = 6'h00;
	logic       pair_ff = 1'b0;
	// Phase runs from an edge request until it wraps back to zero, past the end of earth time
	always_ff @(posedge clock) begin
		if (fire_a || fire_b) begin
			ph_ff   <= 6'h01;
			pair_ff <= fire_b;
		end else if (ph_ff != 6'h00) begin
			ph_ff <= ph_ff + 6'h01;
		end
	end
	// Edge for three cycles, opposite sensor ends earth time later
	assign sens_a_set = !pair_ff && ph_ff inside {[6'h01:6'h03]};
	assign sens_b_set = pair_ff && ph_ff inside {[6'h01:6'h03]};
	assign sens_a_clr = !pair_ff && ph_ff inside {[6'h28:6'h2A]};
	assign sens_b_clr = pair_ff && ph_ff inside {[6'h28:6'h2A]};
endmodule
`default_nettype wire

// >>> test_horizon_sync_spin_clock.sv
// Self-checking bench for the horizon-synchronized spin clock
`timescale 1ns/100ps
`default_nettype none
module test_horizon_sync_spin_clock;
	localparam logic [11:0] WO = 12'h002;
	localparam logic [11:0] FC = 12'h004;
	localparam logic [11:0] SC = 12'h003;
	// Crystal edge on nearly every clock and a short binary chain keep ticks close
	localparam logic [31:0] XS        = 32'hFFFF_FFFF;
	localparam int          D2        = 4;
	localparam int          TICK_CLKS = (2 ** D2) * 3; // Binary stages, then divide by three
	logic      clock     = 1'b0;
	logic      rst_b     = 1'b0;
	logic      load_done = 1'b0;
	logic      tq_mode   = 1'b0;
	logic      cam_sel   = 1'b0;
	logic      fire_a    = 1'b0;
	logic      fire_b    = 1'b0;
	wire logic sa_set, sa_clr, sb_set, sb_clr;
	wire logic tick_400, horizon_pulse, spin_clock, window_open, synced;
	int        n_fail      = 0;
	int        comparisons = 0;
	int        tick_no     = 0;
	int        spin_tick   = 0;
	int        gap         = 0;
	int        n_spin      = 0;
	int        n_hor       = 0;
	int        cyc         = 0;
	int        tick_cyc    = 0;
	int        tick_len    = 0;

	// System clock, 10 ns
	always #5 clock = ~clock;

	hssc_sensor_model SENS (.clock(clock), .fire_a(fire_a), .fire_b(fire_b), .sens_a_set(sa_set),
		.sens_a_clr(sa_clr), .sens_b_set(sb_set), .sens_b_clr(sb_clr));

	hssc_spin_clock #(.WIN_OPEN(WO), .FREE_CLOSE(FC), .SHORT_CLOSE(SC), .XTAL_STEP(XS), .DIV2_STAGES(D2))
		DUT (.clock(clock), .rst_b(rst_b),
		.load_done(load_done), .quarter_orbit_torque_mode(tq_mode), .cam_sel(cam_sel),
		.sens_a_set(sa_set), .sens_a_clr(sa_clr), .sens_b_set(sb_set), .sens_b_clr(sb_clr),
		.tick_400(tick_400), .horizon_pulse(horizon_pulse), .spin_clock(spin_clock),
		.window_open(window_open), .synced(synced));

	// Tick and strobe bookkeeping
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (tick_400 === 1'b1) begin
			tick_no  <= tick_no + 1;
			tick_len <= cyc - tick_cyc;
			tick_cyc <= cyc;
		end
		if (spin_clock === 1'b1) begin
			n_spin    <= n_spin + 1;
			gap       <= tick_no - spin_tick;
			spin_tick <= tick_no;
		end
		if (horizon_pulse === 1'b1)
			n_hor <= n_hor + 1;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	// Waits for n ticks, then lets the following strobes land
	task automatic wait_ticks(input int n);
		repeat (n) begin
			do
				@(negedge clock);
			while (tick_400 !== 1'b1);
		end
		repeat (3)
			@(negedge clock);
	endtask

	task automatic fire(input logic b);
		@(posedge clock);
		fire_a <= ~b;
		fire_b <= b;
		@(posedge clock);
		fire_a <= 1'b0;
		fire_b <= 1'b0;
	endtask

	task automatic t_idle_start;
		int h0;
		fire(1'b0);
		wait_ticks(2);
		check("idle spins", n_spin, 0);
		check("tick period", tick_len, TICK_CLKS);
		h0 = n_hor;
		check("idle horizon", h0, 1);
		@(posedge clock);
		load_done <= 1'b1;
		fire(1'b0);
		wait_ticks(1);
		check("first spin", n_spin, 1);
		check("horizon count", n_hor, h0 + 1);
	endtask

	task automatic t_sync;
		check("window shut", window_open, 1'b0);
		wait_ticks(int'(WO));
		check("window open", window_open, 1'b1);
		fire(1'b0);
		wait_ticks(1);
		check("window gap", gap, WO + 1);
		check("synced", synced, 1'b1);
	endtask

	task automatic t_early;
		int t0;
		repeat (3) begin
			fire(1'b0);
			wait_ticks(int'(FC));
			check("early gap", gap, FC);
		end
		check("synced", synced, 1'b0);
		t0 = spin_tick;
		fire(1'b0);
		wait_ticks(int'(FC) + 1);
		check("rephase tick", spin_tick, t0 + 1 + FC);
	endtask

	task automatic t_miss;
		int h0;
		int t0;
		h0 = n_hor;
		@(posedge clock);
		cam_sel <= 1'b1;
		fire(1'b0);
		wait_ticks(int'(FC));
		check("free close gap", gap, FC);
		wait_ticks(int'(SC));
		check("short gap", gap, SC);
		check("wrong pair", n_hor, h0);
		fire(1'b1);
		wait_ticks(1);
		check("right pair", n_hor, h0 + 1);
		t0 = spin_tick;
		wait_ticks(int'(FC));
		check("miss rephase", spin_tick, t0 + 1 + FC);
	endtask

	task automatic t_torque;
		int s0;
		@(posedge clock);
		tq_mode <= 1'b1;
		s0 = n_spin;
		while (n_spin == s0)
			wait_ticks(1);
		s0 = n_spin;
		wait_ticks(int'(WO));
		fire(1'b1);
		wait_ticks(1);
		check("torque spins", n_spin, s0);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (4)
			@(posedge clock);
		rst_b <= 1'b1;
		t_idle_start();
		t_sync();
		t_sync();
		t_early();
		t_sync();
		t_miss();
		t_torque();
		give_verdict();
	end

	// Watchdog, about two hundred ticks
	initial begin
		#100_000;
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
